// ==== pkg/tcr_defs.svh ====
// Register offsets, field positions, reset values and timing constants
`ifndef TCR_DEFS_SVH
`define TCR_DEFS_SVH
`define TCR_ADDR_CONTROL 8'hC8
`define TCR_ADDR_MODE 8'hC9
`define TCR_ADDR_RCAP_LO 8'hCA
`define TCR_ADDR_RCAP_HI 8'hCB
`define TCR_ADDR_CNT_LO 8'hCC
`define TCR_ADDR_CNT_HI 8'hCD
`define TCR_CTL_RESET 8'h00
`define TCR_MODE_RESET 8'hFE
`define TCR_BYTE_RESET 8'h00
`define TCR_READ_IDLE 8'h00
`define TCR_BIT_OVF 7
`define TCR_BIT_EXT 6
`define TCR_BIT_RXB 5
`define TCR_BIT_TXB 4
`define TCR_BIT_TRIG_EN 3
`define TCR_BIT_RUN 2
`define TCR_BIT_SRC 1
`define TCR_BIT_CAP 0
`define TCR_BIT_DOWN 0
`define TCR_DIV_FAST 4'h3
`define TCR_DIV_SLOW 4'hB
`define TCR_DIV_ZERO 4'h0
`define TCR_CNT_MAX 16'hFFFF
`define TCR_CNT_ONE 16'h0001
`endif

// ==== pkg/tcr_pkg.sv ====
// Types shared by the timer block
package tcr_pkg;
  typedef struct packed {
    logic overflow_flag;
    logic external_flag;
    logic rx_baud_select;
    logic tx_baud_select;
    logic ext_trigger_enable;
    logic run_control;
    logic count_source_select;
    logic capture_reload_select;
  } tcr_control_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tcr_sfr_req_t;
endpackage

// ==== rtl/tcr_timer.sv ====
// Third timer/counter with capture, auto-reload and baud generation
`timescale 1ns/1ps
`include "tcr_defs.svh"
// Function
// - Set overflow flag on 16-bit count overflow
// - Down-count: set flag when count equals reload
// - Hardware sets overflow only with baud bits clear
// - Hardware never clears overflow; software sets/clears
// - External flag set by trigger falling edge
// - Interrupt on software-set or edge-set external flag
// - Receiver clock from timer1 or this timer
// - Transmitter clock from timer1 or this timer
// - Either baud bit forces baud generator mode
// - Trigger edges ignored unless enabled and not baud
// - Count only while run control set
// - Timer prescaled clock or external falling edges
// - Baud mode counts once every two clocks
// - Baud mode always reloads after overflow
// - Reload mode: overflow or trigger edge reloads
// - Capture mode: trigger edge captures count
// - Capture copies low and high bytes
// - Down enable: trigger high up, low down
// - Reset mode FEh, others 00h, all read/write
// - Timer ticks at clock/4 or clock/12
module tcr_timer
  import tcr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire tcr_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic fast_prescale_select_i,
  input wire logic count_edge_input_i,
  input wire logic ext_trigger_input_i,
  input wire logic timer1_overflow_i,
  output logic rx_baud_tick_o,
  output logic tx_baud_tick_o,
  output logic timer_irq_o
);
  tcr_control_t ctl;
  logic [7:0] mode;
  logic [15:0] reload;
  logic [15:0] count;
  logic [3:0] prescale;
  logic half;
  logic [1:0] trig_sync;
  logic [1:0] edge_sync;
  logic trig_prev;
  logic edge_prev;
  logic trig_fall;
  logic edge_fall;
  logic baud_mode;
  logic tick;
  logic count_up;
  logic overflow;
  logic hit;
  logic trig_active;
  logic down_en;
  logic own_ovf;
  logic [15:0] next_count;

  function automatic logic sel(input logic [7:0] a, input logic [7:0] o);
    sel = sfr_req_i.wr && (a == o);
  endfunction

  assign down_en = mode[`TCR_BIT_DOWN];
  assign baud_mode = ctl.rx_baud_select | ctl.tx_baud_select;
  assign trig_fall = trig_prev & ~trig_sync[1];
  assign edge_fall = edge_prev & ~edge_sync[1];
  assign trig_active = trig_fall & ctl.ext_trigger_enable & ~baud_mode;

  // Synchronise pins; first stage feeds only the second
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      trig_sync <= 2'h3;
      edge_sync <= 2'h3;
      trig_prev <= 1'b1;
      edge_prev <= 1'b1;
    end
    else
    begin
      trig_sync <= {trig_sync[0], ext_trigger_input_i};
      edge_sync <= {edge_sync[0], count_edge_input_i};
      trig_prev <= trig_sync[1];
      edge_prev <= edge_sync[1];
    end
  end

  // Prescaler runs freely so the tick rate does not depend on run timing
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prescale <= `TCR_DIV_ZERO;
      half <= 1'b0;
    end
    else
    begin
      half <= ~half;
      if (prescale == `TCR_DIV_ZERO)
        prescale <= fast_prescale_select_i ? `TCR_DIV_FAST
                                           : `TCR_DIV_SLOW;
      else
        prescale <= prescale - 4'h1;
    end
  end

  always_comb
  begin
    if (!ctl.run_control)
      tick = 1'b0;
    else if (baud_mode)
      tick = half;
    else if (ctl.count_source_select)
      tick = edge_fall;
    else
      tick = (prescale == `TCR_DIV_ZERO);
  end

  // Direction only matters in plain auto-reload mode
  assign count_up = baud_mode || ctl.capture_reload_select || !down_en ||
                    trig_sync[1];
  assign overflow = tick && count_up && (count == `TCR_CNT_MAX);
  assign hit = tick && !count_up && (count == reload);
  assign own_ovf = overflow | hit;

  always_comb
  begin
    if (count_up)
      next_count = count + `TCR_CNT_ONE;
    else
      next_count = count - `TCR_CNT_ONE;
    if (overflow && (baud_mode || !ctl.capture_reload_select))
      next_count = reload;
    else if (hit)
      next_count = `TCR_CNT_MAX;
  end

  // Count register; software writes take priority over counting
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      count <= {`TCR_BYTE_RESET, `TCR_BYTE_RESET};
    else if (sel(sfr_req_i.addr, `TCR_ADDR_CNT_LO))
      count[7:0] <= sfr_req_i.wdata;
    else if (sel(sfr_req_i.addr, `TCR_ADDR_CNT_HI))
      count[15:8] <= sfr_req_i.wdata;
    else if (trig_active && !ctl.capture_reload_select)
      count <= reload;
    else if (tick)
      count <= next_count;
  end

  // Capture/reload pair
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      reload <= {`TCR_BYTE_RESET, `TCR_BYTE_RESET};
    else if (sel(sfr_req_i.addr, `TCR_ADDR_RCAP_LO))
      reload[7:0] <= sfr_req_i.wdata;
    else if (sel(sfr_req_i.addr, `TCR_ADDR_RCAP_HI))
      reload[15:8] <= sfr_req_i.wdata;
    else if (trig_active && ctl.capture_reload_select)
      reload <= count;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      mode <= `TCR_MODE_RESET;
    else if (sel(sfr_req_i.addr, `TCR_ADDR_MODE))
      mode <= sfr_req_i.wdata;
  end

  // Control register; hardware set wins over a software clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ctl <= tcr_control_t'(`TCR_CTL_RESET);
    else
    begin
      if (sel(sfr_req_i.addr, `TCR_ADDR_CONTROL))
        ctl <= tcr_control_t'(sfr_req_i.wdata);
      if (own_ovf && !baud_mode)
        ctl.overflow_flag <= 1'b1;
      if (trig_active || (own_ovf && down_en && !baud_mode &&
                          !ctl.capture_reload_select))
        ctl.external_flag <= 1'b1;
    end
  end

  // Read data is registered
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      sfr_rdata_o <= `TCR_READ_IDLE;
    else if (sfr_req_i.rd)
      unique case (sfr_req_i.addr)
        `TCR_ADDR_CONTROL: sfr_rdata_o <= ctl;
        `TCR_ADDR_MODE: sfr_rdata_o <= mode;
        `TCR_ADDR_RCAP_LO: sfr_rdata_o <= reload[7:0];
        `TCR_ADDR_RCAP_HI: sfr_rdata_o <= reload[15:8];
        `TCR_ADDR_CNT_LO: sfr_rdata_o <= count[7:0];
        `TCR_ADDR_CNT_HI: sfr_rdata_o <= count[15:8];
        default: sfr_rdata_o <= `TCR_READ_IDLE;
      endcase
  end

  // Baud ticks: one-cycle strobes, chosen per direction
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rx_baud_tick_o <= 1'b0;
      tx_baud_tick_o <= 1'b0;
    end
    else
    begin
      rx_baud_tick_o <= ctl.rx_baud_select ? overflow
                                           : timer1_overflow_i;
      tx_baud_tick_o <= ctl.tx_baud_select ? overflow
                                           : timer1_overflow_i;
    end
  end

  assign timer_irq_o = ctl.overflow_flag | ctl.external_flag;

  a_ovf_sets_flag: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (overflow && !baud_mode) |=> ctl.overflow_flag)
    else $error("overflow did not set flag");
  a_baud_no_flag: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (baud_mode && !ctl.overflow_flag &&
     !sel(sfr_req_i.addr, `TCR_ADDR_CONTROL)) |=> !ctl.overflow_flag)
    else $error("flag set in baud mode");
  a_halt_holds: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (!ctl.run_control && !sfr_req_i.wr && !trig_active)
    |=> count == $past(count))
    else $error("count moved while halted");
  a_baud_reload: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (overflow && baud_mode && !sfr_req_i.wr) |=> count == $past(reload))
    else $error("baud overflow did not reload");
  a_capture_copy: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (trig_active && ctl.capture_reload_select && !sfr_req_i.wr)
    |=> reload == $past(count))
    else $error("capture did not copy count");
  a_edge_ext_flag: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    trig_active |=> ctl.external_flag)
    else $error("trigger edge lost");
  a_irq_follows: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    timer_irq_o == (ctl.overflow_flag || ctl.external_flag))
    else $error("irq mismatch");
  a_baud_rate: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (tick && baud_mode) |=> !tick)
    else $error("baud ticks too fast");
  a_rx_source: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (!ctl.rx_baud_select && timer1_overflow_i) |=> rx_baud_tick_o)
    else $error("rx tick missing");
  a_trig_ignored: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (!ctl.ext_trigger_enable && !sfr_req_i.wr) |=> reload == $past(reload))
    else $error("trigger not ignored");
  // Watch register effects, so a broken decode term cannot hide itself
  a_tx_source: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (!ctl.tx_baud_select && timer1_overflow_i) |=> tx_baud_tick_o)
    else $error("tx tick missing");
  a_rx_own: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (ctl.rx_baud_select && overflow) |=> rx_baud_tick_o)
    else $error("rx own tick missing");
  a_hit_flag: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    hit |=> ctl.overflow_flag)
    else $error("down hit did not set flag");
  a_hit_wraps: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (hit && !sfr_req_i.wr && !trig_active) |=> count == `TCR_CNT_MAX)
    else $error("down hit did not wrap");
  a_ovf_reload: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (overflow && !baud_mode && !ctl.capture_reload_select &&
     !sfr_req_i.wr) |=> count == $past(reload))
    else $error("overflow did not reload");
  a_trig_reload: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (trig_active && !ctl.capture_reload_select && !sfr_req_i.wr)
    |=> count == $past(reload))
    else $error("trigger did not reload");
  a_flag_kept: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (ctl.overflow_flag && !sel(sfr_req_i.addr, `TCR_ADDR_CONTROL))
    |=> ctl.overflow_flag)
    else $error("overflow flag cleared by hardware");
  a_ext_kept: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (ctl.external_flag && !sel(sfr_req_i.addr, `TCR_ADDR_CONTROL))
    |=> ctl.external_flag)
    else $error("external flag cleared by hardware");
  a_down_step: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (tick && !count_up && !hit && !sfr_req_i.wr && !trig_active)
    |=> count == $past(count) - `TCR_CNT_ONE)
    else $error("down step wrong");
endmodule // tcr_timer

// ==== sim/tcr_core_model.sv ====
// Processor core model driving the special-function-register bus
`timescale 1ns/1ps
module tcr_core_model
  import tcr_pkg::*;
(
  input wire logic sys_clk_i,
  output tcr_sfr_req_t sfr_req_o,
  input wire logic [7:0] sfr_rdata_i
);
  initial sfr_req_o = '0;
  // Strobe stands for exactly one taking edge, then the bus idles
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    sfr_req_o <= '{1'b1, 1'b0, a, v};
    @(posedge sys_clk_i);
    sfr_req_o <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk_i);
    sfr_req_o <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk_i);
    sfr_req_o <= '0;
    @(posedge sys_clk_i);
    v = sfr_rdata_i;
  endtask
  // Rounded to nearest, since the divide rarely comes out whole
  function automatic logic [15:0] baud_reload(longint f, longint b);
    return 16'(65536 - (f + 16 * b) / (32 * b));
  endfunction
endmodule // tcr_core_model

// ==== sim/testbench.sv ====
// Self-checking bench for the third timer block
`timescale 1ns/1ps
`include "tcr_defs.svh"
`define CHK(nm, ex, got) \
  begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module testbench
  import tcr_pkg::*;
;
  localparam logic [7:0] CTL = `TCR_ADDR_CONTROL, MD = `TCR_ADDR_MODE;
  localparam logic [7:0] RLO = `TCR_ADDR_RCAP_LO, RHI = `TCR_ADDR_RCAP_HI;
  localparam logic [7:0] CLO = `TCR_ADDR_CNT_LO, CHI = `TCR_ADDR_CNT_HI;
  logic sys_clk, reset_n, fast, edge_in, trig, t1_ovf, rx_tick, tx_tick, irq;
  logic [7:0] rdata, d;
  logic [15:0] rl;
  tcr_sfr_req_t req;
  int n_mismatch = 0, compares = 0, nrx = 0, ntx = 0, r0, t0;

  tcr_core_model tcr_core_model_inst (.sys_clk_i(sys_clk), .sfr_req_o(req),
    .sfr_rdata_i(rdata));
  tcr_timer tcr_timer_inst (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
    .sfr_req_i(req), .sfr_rdata_o(rdata), .fast_prescale_select_i(fast),
    .count_edge_input_i(edge_in), .ext_trigger_input_i(trig),
    .timer1_overflow_i(t1_ovf), .rx_baud_tick_o(rx_tick),
    .tx_baud_tick_o(tx_tick), .timer_irq_o(irq));

  always @(posedge sys_clk)
  begin
    nrx += (rx_tick === 1'b1);
    ntx += (tx_tick === 1'b1);
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    tcr_core_model_inst.wr(a, v);
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e, input string n);
    tcr_core_model_inst.rd(a, d);
    `CHK(n, e, d)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic t1_pulses();
    repeat (8)
    begin
      t1_ovf <= 1;
      cyc(1);
      t1_ovf <= 0;
      cyc(4);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    cyc(5000);
    n_mismatch++;
    conclude();
  end
  initial
  begin
    reset_n = 0; fast = 0; edge_in = 1; trig = 1; t1_ovf = 0;
    cyc(8);
    reset_n <= 1;
    chk(CTL, 8'h00, "control");
    chk(MD, 8'hFE, "mode");
    for (int a = 'hCA; a <= 'hCD; a++)
      chk(8'(a), 8'h00, "byte reset");
    chk(8'hC0, 8'h00, "unmapped");
    $display("reset test done");
    fast <= 1;
    wr(CTL, 8'h04);
    cyc(120);
    wr(CTL, 8'h00);
    tcr_core_model_inst.rd(CLO, d);
    `CHK("fast ticks", 1'b1, d >= 29 && d <= 32)
    cyc(20);
    chk(CLO, d, "halted count");
    wr(CLO, 8'h00);
    fast <= 0;
    wr(CTL, 8'h04);
    cyc(120);
    wr(CTL, 8'h00);
    tcr_core_model_inst.rd(CLO, d);
    `CHK("slow ticks", 1'b1, d >= 9 && d <= 11)
    $display("prescale test done");
    fast <= 1;
    wr(RLO, 8'h34);
    wr(RHI, 8'h12);
    wr(CLO, 8'hFE);
    wr(CHI, 8'hFF);
    wr(CTL, 8'h04);
    cyc(30);
    chk(CTL, 8'h84, "overflow");
    `CHK("irq ovf", 1'b1, irq)
    wr(CTL, 8'h80);
    chk(CHI, 8'h12, "reload high");
    wr(CTL, 8'h40);
    chk(CTL, 8'h40, "soft flags");
    `CHK("irq soft", 1'b1, irq)
    wr(CTL, 8'h00);
    cyc(1);
    `CHK("irq idle", 1'b0, irq)
    $display("overflow test done");
    wr(CLO, 8'hCD);
    wr(CHI, 8'hAB);
    wr(CTL, 8'h09);
    trig <= 0;
    cyc(6);
    chk(RLO, 8'hCD, "capture low");
    chk(RHI, 8'hAB, "capture high");
    chk(CTL, 8'h49, "edge flag");
    `CHK("irq edge", 1'b1, irq)
    trig <= 1;
    wr(CTL, 8'h01);
    wr(CHI, 8'h55);
    trig <= 0;
    cyc(6);
    chk(RHI, 8'hAB, "no capture");
    chk(CTL, 8'h01, "no edge flag");
    trig <= 1;
    wr(CTL, 8'h08);
    trig <= 0;
    cyc(6);
    chk(CHI, 8'hAB, "trigger reload");
    $display("trigger test done");
    trig <= 1;
    wr(CHI, 8'h00);
    wr(CLO, 8'h00);
    wr(CTL, 8'h06);
    repeat (3)
    begin
      edge_in <= 0;
      cyc(4);
      edge_in <= 1;
      cyc(4);
    end
    wr(CTL, 8'h02);
    chk(CLO, 8'h03, "edge count");
    trig <= 0;
    wr(MD, 8'hFF);
    wr(RLO, 8'h05);
    wr(RHI, 8'h00);
    wr(CLO, 8'h09);
    wr(CTL, 8'h04);
    cyc(30);
    tcr_core_model_inst.rd(CTL, d);
    `CHK("down flag", 8'hC4, d)
    wr(CTL, 8'h00);
    chk(CHI, 8'hFF, "down wrap");
    wr(MD, 8'hFE);
    trig <= 1;
    $display("counter test done");
    rl = tcr_core_model_inst.baud_reload(200000000, 3125000);
    wr(RLO, rl[7:0]);
    wr(RHI, rl[15:8]);
    wr(CLO, 8'hFE);
    wr(CHI, 8'hFF);
    r0 = nrx;
    t0 = ntx;
    wr(CTL, 8'h17);
    t1_pulses();
    wr(CTL, 8'h13);
    `CHK("rx ticks", 8, nrx - r0)
    `CHK("tx ticks", 1, ntx - t0 >= 9 && ntx - t0 <= 12)
    chk(CTL, 8'h13, "baud flags");
    r0 = nrx;
    t0 = ntx;
    wr(CTL, 8'h24);
    t1_pulses();
    wr(CTL, 8'h20);
    `CHK("tx t1 ticks", 8, ntx - t0)
    `CHK("rx own ticks", 1, nrx - r0 >= 9 && nrx - r0 <= 12)
    chk(CTL, 8'h20, "rx baud flags");
    $display("baud test done");
    conclude();
  end
endmodule // testbench
